// ---- rtl/bld_pkg.sv ----
// Package with instruction field layout and encodings for the branch and load decoder.
package bld_pkg;
  localparam int INSTR_W = 23;
  localparam int PC_W = 11;
  localparam int DATA_W = 16;
  // Instruction class field, bits 22:21.
  localparam int CLASS_HI = 22;
  localparam int CLASS_LO = 21;
  localparam logic [1:0] CLASS_JUMP = 2'h2;
  localparam logic [1:0] CLASS_LOAD = 2'h3;
  // Branch type field, bits 20:18.
  localparam int BRANCH_HI = 20;
  localparam int BRANCH_LO = 18;
  localparam logic [2:0] BRANCH_JUMP = 3'h4;
  localparam logic [2:0] BRANCH_CALL = 3'h5;
  localparam logic [2:0] BRANCH_COND = 3'h2;
  // Condition select field, bits 17:13.
  localparam int COND_HI = 17;
  localparam int COND_LO = 13;
  localparam logic [4:0] COND_NONE = 5'h00;
  // Next address field, bits 12:2.
  localparam int NEXT_ADDR_HI = 12;
  localparam int NEXT_ADDR_LO = 2;
  // Load: immediate bits 20:5, clear of the class field, destination bits 3:0.
  localparam int IMM_HI = 20;
  localparam int IMM_LO = 5;
  localparam int DEST_HI = 3;
  localparam int DEST_LO = 0;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [3:0] NIBBLE_FULL = 4'hf;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam int RESET_MIN_CYCLES = 4;
  localparam int INT_MIN_CYCLES = 8;
  localparam int INSTR_CYCLE_NS = 240;

  typedef struct packed {
    logic carry_flag_a;
    logic carry_flag_b;
    logic zero_flag_a;
    logic zero_flag_b;
    logic overflow0_flag_a;
    logic overflow0_flag_b;
    logic overflow1_flag_a;
    logic overflow1_flag_b;
    logic sign0_flag_a;
    logic sign0_flag_b;
    logic sign1_flag_a;
    logic sign1_flag_b;
    logic [3:0] data_pointer_low_nibble;
    logic serial_in_acknowledge;
    logic serial_out_acknowledge;
    logic host_data_request_flag;
  } bld_flags_type;
endpackage

// ---- rtl/bld_decoder.sv ----
// Branch and load-immediate decoder with program counter and return address capture.
// Function
// - Load immediate writes 16-bit operand into register chosen by destination field.
// - Branch type 100 decodes as unconditional jump, condition bits zero.
// - Branch type 101 decodes as unconditional call, condition bits zero.
// - Branch type 010 is conditional jump, test chosen by bits 17 to 13.
// - Codes 00000 to 00011 test carry A and carry B clear or set.
// - Codes 00100 to 00111 test zero A and zero B clear or set.
// - Codes 01000 to 01011 test overflow 0 of A and B.
// - Codes 01100 to 01111 test overflow 1 of A and B.
// - Codes 10000 to 10011 test sign 0 of A and B.
// - Codes 10100 to 10111 test sign 1 of A and B.
// - Code 11000 jumps on pointer nibble zero, 11001 on nibble F.
// - Codes 11010 and 11011 test serial input acknowledge 0 or 1.
// - Codes 11100 and 11101 test serial output acknowledge 0 or 1.
// - Codes 11110 and 11111 test host data request 0 or 1.
// - Taken jump or call loads next address; otherwise counter adds one.
// - Each 23-bit instruction completes in one instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module bld_decoder
  import bld_pkg::*;
#(
  parameter int PC_WIDTH = PC_W
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic INSTR_VALID,
  input wire logic [INSTR_W-1:0] INSTR_WORD,
  input wire bld_flags_type FLAGS,
  output logic [PC_WIDTH-1:0] PC,
  output logic LOAD_WRITE,
  output logic [3:0] LOAD_DEST,
  output logic [DATA_W-1:0] LOAD_DATA,
  output logic CALL_PUSH,
  output logic [PC_WIDTH-1:0] RETURN_ADDR,
  output logic BRANCH_TAKEN,
  output logic ILLEGAL_BRANCH
);

  ////////////////////////////////////////////////////////////////////////////
  // Condition evaluation.

  // Flags come from logic on this clock, so they reach the decode with no synchroniser.
  // A synchroniser here would make every condition test two instructions late.
  // Bit 0 of the code picks the tested polarity, or nibble zero versus F for code 1100x; the upper four bits pick the flag.
  function automatic logic cond_true(input logic [4:0] code, input bld_flags_type f);
    logic sel;
    logic nib_zero;
    logic nib_full;
    sel = 1'b0;
    nib_zero = (f.data_pointer_low_nibble == NIBBLE_ZERO);
    nib_full = (f.data_pointer_low_nibble == NIBBLE_FULL);
    unique case (code[4:1])
      4'h0: sel = f.carry_flag_a;
      4'h1: sel = f.carry_flag_b;
      4'h2: sel = f.zero_flag_a;
      4'h3: sel = f.zero_flag_b;
      4'h4: sel = f.overflow0_flag_a;
      4'h5: sel = f.overflow0_flag_b;
      4'h6: sel = f.overflow1_flag_a;
      4'h7: sel = f.overflow1_flag_b;
      4'h8: sel = f.sign0_flag_a;
      4'h9: sel = f.sign0_flag_b;
      4'ha: sel = f.sign1_flag_a;
      4'hb: sel = f.sign1_flag_b;
      4'hc: sel = code[0] ? nib_full : nib_zero;
      4'hd: sel = f.serial_in_acknowledge;
      4'he: sel = f.serial_out_acknowledge;
      4'hf: sel = f.host_data_request_flag;
    endcase
    // The nibble test is already polarised, so its select is returned as is.
    if (code[4:1] == 4'hc) begin
      return sel;
    end
    return code[0] ? sel : ~sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode.

  logic [1:0] class_field;
  logic [2:0] branch_type_field;
  logic [4:0] condition_select_field;
  logic [PC_WIDTH-1:0] next_address_field;
  logic is_jump;
  logic is_load;
  logic is_call;
  logic take;
  logic illegal;
  logic [PC_WIDTH-1:0] pc_r;
  logic [PC_WIDTH-1:0] pc_nxt;
  logic [PC_WIDTH-1:0] pc_inc;
  logic cond_clear;

  // Class codes 00 and 01 belong to the arithmetic words, which only step the counter here.
  assign class_field = INSTR_WORD[CLASS_HI:CLASS_LO];
  assign branch_type_field = INSTR_WORD[BRANCH_HI:BRANCH_LO];
  assign condition_select_field = INSTR_WORD[COND_HI:COND_LO];
  assign cond_clear = (condition_select_field == COND_NONE);
  assign next_address_field = PC_WIDTH'(INSTR_WORD[NEXT_ADDR_HI:NEXT_ADDR_LO]);
  assign is_jump = INSTR_VALID && (class_field == CLASS_JUMP);
  assign is_load = INSTR_VALID && (class_field == CLASS_LOAD);
  // The step wraps at the top of program memory, as the counter width allows.
  assign pc_inc = PC_WIDTH'(pc_r + PC_WIDTH'(PC_STEP));

  always_comb begin
    take = 1'b0;
    illegal = 1'b0;
    is_call = 1'b0;
    // Jump and call must carry an all-zero condition field; other words except type 010 are prohibited.
    if (is_jump) begin
      if (branch_type_field == BRANCH_JUMP && cond_clear) begin
        take = 1'b1;
      end else if (branch_type_field == BRANCH_CALL && cond_clear) begin
        take = 1'b1;
        is_call = 1'b1;
      // conditional jump, flags sampled at cycle end
      end else if (branch_type_field == BRANCH_COND) begin
        take = cond_true(condition_select_field, FLAGS);
      end else begin
        // Prohibited codes fall through as a plain step and are only flagged.
        illegal = 1'b1;
      end
    end
  end

  // next address or step, one instruction per cycle
  // Without a valid word the counter holds, so fetch stalls need no extra state.
  always_comb begin
    pc_nxt = pc_r;
    if (INSTR_VALID) begin
      pc_nxt = take ? next_address_field : pc_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.
  // Each strobe register below loads on every edge, so it pulses one cycle per decoded word; LOAD_DEST, LOAD_DATA and RETURN_ADDR load only on their decode.

  // Reset starts fetch at the first program word.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pc_r <= PC_WIDTH'(PC_RESET);
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      LOAD_WRITE <= 1'b0;
      LOAD_DEST <= 4'h0;
      LOAD_DATA <= 16'h0000;
    end else begin
      LOAD_WRITE <= is_load;
      // Destination and data stand until the next load, so the register file may latch late.
      if (is_load) begin
        LOAD_DEST <= INSTR_WORD[DEST_HI:DEST_LO];
        LOAD_DATA <= INSTR_WORD[IMM_HI:IMM_LO];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      CALL_PUSH <= 1'b0;
      RETURN_ADDR <= PC_WIDTH'(PC_RESET);
    end else begin
      CALL_PUSH <= is_call;
      // The saved address is the step value, taken before the counter moves,
      // so a call from the last word returns to address zero.
      if (is_call) begin
        RETURN_ADDR <= pc_inc;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      BRANCH_TAKEN <= 1'b0;
    end else begin
      BRANCH_TAKEN <= take;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ILLEGAL_BRANCH <= 1'b0;
    end else begin
      ILLEGAL_BRANCH <= illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The counter register drives the port directly, so the fetch address never glitches.
  assign PC = pc_r;

endmodule
`default_nettype wire

// ---- sim/bld_decoder_assertions.sv ----
// Port checker for the branch and load decoder.
`timescale 1ns/1ps
`default_nettype none
module bld_decoder_assertions
  import bld_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic INSTR_VALID,
  input wire logic [INSTR_W-1:0] INSTR_WORD,
  input wire bld_flags_type FLAGS,
  input wire logic [PC_W-1:0] PC,
  input wire logic LOAD_WRITE,
  input wire logic [3:0] LOAD_DEST,
  input wire logic [DATA_W-1:0] LOAD_DATA,
  input wire logic CALL_PUSH,
  input wire logic [PC_W-1:0] RETURN_ADDR,
  input wire logic BRANCH_TAKEN,
  input wire logic ILLEGAL_BRANCH
);
  logic [22:0] w;
  logic [10:0] np;
  logic j;
  logic c;
  assign w = INSTR_WORD;
  assign np = PC + PC_STEP;
  assign j = INSTR_VALID && w[22:21] == CLASS_JUMP;
  assign c = j && w[20:18] == BRANCH_COND;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  a_load_write: assert property (INSTR_VALID && w[22:21] == CLASS_LOAD |=> LOAD_WRITE
    && {LOAD_DATA, LOAD_DEST} == $past({w[IMM_HI:IMM_LO], w[DEST_HI:DEST_LO]}))
    else $error("load wrong");
  a_jump_target: assert property (j && w[20:13] == {BRANCH_JUMP, COND_NONE} |=>
    BRANCH_TAKEN && PC == $past(w[12:2])) else $error("jump wrong");
  a_call_return: assert property (j && w[20:13] == {BRANCH_CALL, COND_NONE} |=>
    CALL_PUSH && RETURN_ADDR == $past(np)) else $error("call wrong");
  a_flag_test: assert property (c && w[17:14] < 4'hc |=>
    BRANCH_TAKEN == $past(FLAGS[18 - w[17:14]] == w[13])) else $error("flag test wrong");
  a_nibble_test: assert property (c && w[17:14] == 4'hc |=>
    BRANCH_TAKEN == $past(FLAGS.data_pointer_low_nibble == {4{w[13]}}))
    else $error("nibble test wrong");
  a_ack_test: assert property (c && w[17:14] > 4'hc |=>
    BRANCH_TAKEN == $past(FLAGS[15 - w[17:14]] == w[13])) else $error("ack test wrong");
  a_taken_target: assert property (j |=>
    PC == (BRANCH_TAKEN ? $past(w[12:2]) : $past(np))) else $error("next pc wrong");
  a_idle_hold: assert property (!INSTR_VALID |=>
    $stable(PC) && !(LOAD_WRITE || CALL_PUSH)) else $error("idle not held");
  a_illegal_flag: assert property (j && w[20:18] != BRANCH_COND
    && w[20:13] != {BRANCH_JUMP, COND_NONE} && w[20:13] != {BRANCH_CALL, COND_NONE}
    |=> ILLEGAL_BRANCH && !BRANCH_TAKEN) else $error("prohibited word not flagged");
endmodule
bind bld_decoder bld_decoder_assertions u_chk (.CLK_SYS, .RESETN, .INSTR_VALID, .INSTR_WORD,
  .FLAGS, .PC, .LOAD_WRITE, .LOAD_DEST, .LOAD_DATA, .CALL_PUSH, .RETURN_ADDR, .BRANCH_TAKEN,
  .ILLEGAL_BRANCH);
`default_nettype wire

// ---- sim/bld_fetch_model.sv ----
// Fetch stage model that hands one instruction word to the decoder.
`timescale 1ns/1ps
`default_nettype none
module bld_fetch_model
  import bld_pkg::*;
(
  input wire logic clk,
  output logic valid,
  output logic [INSTR_W-1:0] word
);
  initial valid = 1'b0;
  initial word = '0;
  // interrupt requests are not modelled, as this decoder has no interrupt input.
  task automatic issue(input logic [INSTR_W-1:0] w);
    @(posedge clk);
    #1 valid = 1'b1;
    word = w;
    @(posedge clk);
    #1 valid = 1'b0;
    // Idle word is the inverse so a stale value cannot pass as a fresh one.
    word = ~w;
  endtask
endmodule
`default_nettype wire

// ---- sim/bld_decoder_tb.sv ----
// Self-checking bench for the branch and load decoder.
`timescale 1ns/1ps
`default_nettype none
module bld_decoder_tb
  import bld_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld, lw, cp, bt, ib;
  logic [INSTR_W-1:0] wd;
  bld_flags_type fl = '0;
  logic [PC_W-1:0] pc, ra, p0;
  logic [3:0] ld;
  logic [DATA_W-1:0] dat;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  bld_fetch_model fm (.clk(clk), .valid(vld), .word(wd));
  bld_decoder dut (.CLK_SYS(clk), .RESETN(rst_n), .INSTR_VALID(vld), .INSTR_WORD(wd),
    .FLAGS(fl), .PC(pc), .LOAD_WRITE(lw), .LOAD_DEST(ld), .LOAD_DATA(dat), .CALL_PUSH(cp),
    .RETURN_ADDR(ra), .BRANCH_TAKEN(bt), .ILLEGAL_BRANCH(ib));
  task automatic chk(input string n, input logic [22:0] e, input logic [22:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [22:0] jw(input logic [7:0] bc, input logic [10:0] a);
    return {CLASS_JUMP, bc, a, 2'h0};
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic t_load;
    p0 = pc;
    fm.issue({CLASS_LOAD, 16'h5c3a, 1'b0, 4'h6});
    chk("load", {1'b1, 16'h5c3a, 4'h6}, {lw, dat, ld});
    chk("load pc", p0 + PC_STEP, pc);
    $display("load test done");
  endtask
  task automatic t_jump;
    fm.issue(jw({BRANCH_JUMP, COND_NONE}, 11'h123));
    chk("jump", {1'b1, 11'h123}, {bt, pc});
    fm.issue(jw({BRANCH_CALL, COND_NONE}, 11'h040));
    chk("call", {1'b1, 11'h124, 11'h040}, {cp, ra, pc});
    $display("jump test done");
  endtask
  task automatic t_cond;
    logic [18:0] m;
    logic [4:0] c;
    // Only the tested flag differs from the rest, so a wrong selection shows.
    for (int i = 0; i < 64; i++) begin
      c = i[5:1];
      m = c[4:1] < 12 ? 19'h1 << (18 - c[4:1]) : 19'h1 << (15 - c[4:1]);
      if (c[4:1] == 12) m = 19'h78;
      fl = bld_flags_type'(i[0] ? m : ~m);
      p0 = pc;
      fm.issue(jw({BRANCH_COND, c}, 11'h2aa));
      chk("cond", {i[0] == c[0], i[0] == c[0] ? 11'h2aa : p0 + PC_STEP}, {bt, pc});
    end
    $display("condition test done");
  endtask
  task automatic t_ill;
    p0 = pc;
    fm.issue(jw({3'h7, COND_NONE}, 11'h155));
    chk("bad type", {1'b1, p0 + PC_STEP}, {ib, pc});
    fm.issue(jw({BRANCH_JUMP, 5'h03}, 11'h155));
    chk("bad cond", {1'b1, p0 + 11'h002}, {ib, pc});
    repeat (2) @(posedge clk);
    #1 chk("idle", {1'b0, p0 + 11'h002}, {ib, pc});
    fm.issue(23'h000000);
    chk("other class", {4'h0, p0 + 11'h003}, {ib, lw, bt, cp, pc});
    $display("prohibited code test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_load();
    t_jump();
    t_cond();
    t_ill();
    end_sim();
  end
endmodule
`default_nettype wire
